/* File: src/sscw_pkg.sv */
// Purpose: Constants for the serial control word bank of the synthesizer.
// Assumes: Control words are 32 bits, latch select sits in the three lowest bits.
// Notes: Field positions below follow the register layout of each latch.
// Function
// - Each 32-bit word is shifted in most significant bit first, one bit per rising serial clock edge.
// - A rising load strobe copies the shift register into the latch chosen by the three lowest bits.
// - Code 000 updates the integer and fractional divide register.
// - Code 001 updates the prescaler, phase and modulus register.
// - Codes 010, 011, 100 and 101 select the third to sixth latches.
// - The first register holds a sixteen-bit integer divide word.
// - The first register holds a twelve-bit fractional numerator.
// - One prescaler select bit chooses between 4/5 and 8/9.
// - Double-buffered fields take effect only on a later first-register write.
// - Output divider bits are double-buffered only while the buffer enable bit of the third register is high.
// - A first-register write starts band selection lasting ten reference cycles times the band clock divider.
package sscw_pkg;
  localparam int WORD_W = 32;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_INTFRAC = 3'h0;
  localparam logic [2:0] SEL_PHMOD = 3'h1;
  localparam logic [2:0] SEL_REFCP = 3'h2;
  localparam logic [2:0] SEL_CLKDIV = 3'h3;
  localparam logic [2:0] SEL_OUTSTG = 3'h4;
  localparam logic [2:0] SEL_LOCKPIN = 3'h5;
  // Register 0 fields
  localparam int INT_LSB = 15;
  localparam int INT_W = 16;
  localparam int FRACTIONAL_NUMERATOR_LSB = 3;
  localparam int FRACTIONAL_NUMERATOR_W = 12;
  // Register 1 fields
  localparam int PRESC_BIT = 27;
  localparam int PHASE_LSB = 15;
  localparam int MOD_LSB = 3;
  localparam int MOD_W = 12;
  // Register 2 fields
  localparam int DBL_BIT = 25;
  localparam int RDIV2_BIT = 24;
  localparam int RCNT_LSB = 14;
  localparam int RCNT_W = 10;
  localparam int DBUF_EN_BIT = 13;
  localparam int CPCUR_LSB = 9;
  localparam int CPCUR_W = 4;
  // Register 4 fields
  localparam int ODIV_LSB = 20;
  localparam int ODIV_W = 3;
  localparam int BSDIV_LSB = 12;
  localparam int BSDIV_W = 8;
  // Band selection lasts this many reference cycles per divider step
  localparam int BAND_CYCLES = 10;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

/* File: src/sscw_bank.sv */
// Purpose: Serial control word bank with double-buffered fields.
// Assumes: Serial clock, data and load strobe are synchronised into mclk.
// Notes: Band selection time is counted on the refTick enable pulse.
`timescale 1ns/100ps
`default_nettype none
module sscw_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial link pins
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic load_strobe,
  // Reference-rate enable pulse
  input wire logic refTick,
  // Active field values
  output logic [15:0] integerWord,
  output logic [11:0] fractional_numerator,
  output logic prescaler_select,
  output logic [11:0] phaseWord,
  output logic [11:0] fractional_modulus,
  output logic [31:0] refCpWord,
  output logic [31:0] clkDivWord,
  output logic [31:0] outStageWord,
  output logic [31:0] lockPinWord,
  output logic [2:0] outDivider,
  // Band selection status
  output logic bandSelBusy
);
  // Reset synchroniser
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  wire logic rstN = rstSync_r;

  // Pin synchronisers; third stage only for edge detection
  logic [2:0] sclkSh_r, leSh_r;
  logic [1:0] sdatSh_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      sclkSh_r <= 3'h0;
      leSh_r <= 3'h0;
      sdatSh_r <= 2'h0;
    end else begin
      sclkSh_r <= {sclkSh_r[1:0], serialClk};
      leSh_r <= {leSh_r[1:0], load_strobe};
      sdatSh_r <= {sdatSh_r[0], serialData};
    end
  end
  wire logic sclkRise = sclkSh_r[1] & ~sclkSh_r[2];
  wire logic leRise = leSh_r[1] & ~leSh_r[2];

  // Shift register, MSB first
  logic [31:0] shift_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) shift_r <= sscw_pkg::ZERO_WORD;
    else if (sclkRise) shift_r <= {shift_r[30:0], sdatSh_r[1]};
  end

  // Latch decode from the three lowest bits
  wire logic [2:0] latch_select_bits = shift_r[2:0];
  wire logic wrR0 = leRise && (latch_select_bits == sscw_pkg::SEL_INTFRAC);
  wire logic wrR1 = leRise && (latch_select_bits == sscw_pkg::SEL_PHMOD);
  wire logic wrR2 = leRise && (latch_select_bits == sscw_pkg::SEL_REFCP);
  wire logic wrR3 = leRise && (latch_select_bits == sscw_pkg::SEL_CLKDIV);
  wire logic wrR4 = leRise && (latch_select_bits == sscw_pkg::SEL_OUTSTG);
  wire logic wrR5 = leRise && (latch_select_bits == sscw_pkg::SEL_LOCKPIN);

  // Staging latches; buffered fields are copied out of these on a first_register write
  logic [31:0] r1Stage_r, r2Stage_r, r4Stage_r;
  logic [31:0] r1Act_r, r2Act_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      r1Stage_r <= sscw_pkg::ZERO_WORD;
      r2Stage_r <= sscw_pkg::ZERO_WORD;
      r4Stage_r <= sscw_pkg::ZERO_WORD;
    end else begin
      if (wrR1) r1Stage_r <= shift_r;
      if (wrR2) r2Stage_r <= shift_r;
      if (wrR4) r4Stage_r <= shift_r;
    end
  end

  // Buffer enable follows the staged third register, as the device does
  wire logic dbufEn = r2Stage_r[sscw_pkg::DBUF_EN_BIT];
  wire logic [2:0] stagedDiv = r4Stage_r[sscw_pkg::ODIV_LSB +: sscw_pkg::ODIV_W];

  // Marked third-register fields wait for a first_register write; the rest act at once,
  // so a user who rewrites only the charge pump setting sees it after the next commit
  localparam logic [31:0] ONE_WORD = 32'h0000_0001;
  localparam logic [31:0] R2_BUF_MASK = (ONE_WORD << sscw_pkg::DBL_BIT) | (ONE_WORD << sscw_pkg::RDIV2_BIT)
    | (((ONE_WORD << sscw_pkg::RCNT_W) - ONE_WORD) << sscw_pkg::RCNT_LSB)
    | (((ONE_WORD << sscw_pkg::CPCUR_W) - ONE_WORD) << sscw_pkg::CPCUR_LSB);
  wire logic [31:0] r2OnWrite = (r2Act_r & R2_BUF_MASK) | (shift_r & ~R2_BUF_MASK);
  wire logic [31:0] r2OnCommit = (r2Act_r & ~R2_BUF_MASK) | (r2Stage_r & R2_BUF_MASK);

  // First register fields land straight from the shift register
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      integerWord <= 16'h0000;
      fractional_numerator <= 12'h000;
    end else if (wrR0) begin
      integerWord <= shift_r[sscw_pkg::INT_LSB +: sscw_pkg::INT_W];
      fractional_numerator <= shift_r[sscw_pkg::FRACTIONAL_NUMERATOR_LSB +: sscw_pkg::FRACTIONAL_NUMERATOR_W];
    end
  end

  // Phase and modulus wait in staging until the first register is written
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) r1Act_r <= sscw_pkg::ZERO_WORD;
    else if (wrR0) r1Act_r <= r1Stage_r;
  end

  // Third register: unmarked fields act at once, marked fields on the commit
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) r2Act_r <= sscw_pkg::ZERO_WORD;
    else if (wrR0) r2Act_r <= r2OnCommit;
    else if (wrR2) r2Act_r <= r2OnWrite;
  end

  // Divider select: immediate unless the buffer enable bit holds it back
  wire logic [2:0] freshDiv = shift_r[sscw_pkg::ODIV_LSB +: sscw_pkg::ODIV_W];
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) outDivider <= 3'h0;
    else if (wrR0) outDivider <= stagedDiv;
    else if (wrR4 && !dbufEn) outDivider <= freshDiv;
  end

  // Unbuffered words take the shift register on their own strobe
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      clkDivWord <= sscw_pkg::ZERO_WORD;
      outStageWord <= sscw_pkg::ZERO_WORD;
      lockPinWord <= sscw_pkg::ZERO_WORD;
    end else begin
      if (wrR3) clkDivWord <= shift_r;
      if (wrR4) outStageWord <= shift_r;
      if (wrR5) lockPinWord <= shift_r;
    end
  end

  // Prescaler bit is not buffered; phase and modulus are
  logic prescaler_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) prescaler_r <= 1'b0;
    else if (wrR1) prescaler_r <= shift_r[sscw_pkg::PRESC_BIT];
  end
  assign prescaler_select = prescaler_r;
  assign phaseWord = r1Act_r[sscw_pkg::PHASE_LSB +: sscw_pkg::MOD_W];
  assign fractional_modulus = r1Act_r[sscw_pkg::MOD_LSB +: sscw_pkg::MOD_W];
  assign refCpWord = r2Act_r;

  // Band selection timer: ten reference ticks per divider step
  logic [11:0] bandCnt_r;
  wire logic [7:0] band_clock_divider = outStageWord[sscw_pkg::BSDIV_LSB +: sscw_pkg::BSDIV_W];
  wire logic [11:0] bandLoad = 12'(sscw_pkg::BAND_CYCLES) * {4'h0, band_clock_divider};
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) bandCnt_r <= 12'h000;
    else if (wrR0) bandCnt_r <= bandLoad;
    else if (refTick && bandCnt_r != 12'h000) bandCnt_r <= bandCnt_r - 12'h001;
  end
  assign bandSelBusy = (bandCnt_r != 12'h000);

  // Checks
  shift_in_a: assert property (@(posedge mclk) disable iff (!rstN)
    sclkRise |=> shift_r[0] == $past(sdatSh_r[1]))
    else $error("shift bit not captured");
  intword_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR0 |=> integerWord == $past(shift_r[30:15]))
    else $error("integer word not loaded");
  buffered_a: assert property (@(posedge mclk) disable iff (!rstN)
    (wrR1 && !wrR0) |=> fractional_modulus == $past(fractional_modulus))
    else $error("modulus changed without first register write");
  presc_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR1 |=> prescaler_select == $past(shift_r[27]))
    else $error("prescaler not updated");
  divimm_a: assert property (@(posedge mclk) disable iff (!rstN)
    (wrR4 && !dbufEn) |=> outDivider == $past(shift_r[22:20]))
    else $error("divider not immediate");
  divhold_a: assert property (@(posedge mclk) disable iff (!rstN)
    (wrR4 && dbufEn) |=> $stable(outDivider))
    else $error("buffered divider changed early");
  band_start_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR0 |=> bandCnt_r == $past(bandLoad))
    else $error("band timer not started");
  onehot_a: assert property (@(posedge mclk) disable iff (!rstN)
    $onehot0({wrR0, wrR1, wrR2, wrR3, wrR4, wrR5}))
    else $error("more than one latch selected");

  // Shift register moves only on a synchronised serial clock rise
  shift_hold_a: assert property (@(posedge mclk) disable iff (!rstN)
    !sclkRise |=> $stable(shift_r))
    else $error("shift register moved without clock");

  // Codes 110 and 111 must leave every latch alone
  no_latch_a: assert property (@(posedge mclk) disable iff (!rstN)
    (leRise && latch_select_bits > sscw_pkg::SEL_LOCKPIN) |=> ($stable(r1Stage_r) && $stable(r2Stage_r)
      && $stable(r4Stage_r) && $stable(clkDivWord) && $stable(lockPinWord) && $stable(integerWord)))
    else $error("reserved code touched a latch");

  // Fractional numerator loads with the integer word
  r0_fractional_numerator_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR0 |=> fractional_numerator == $past(shift_r[sscw_pkg::FRACTIONAL_NUMERATOR_LSB +: sscw_pkg::FRACTIONAL_NUMERATOR_W]))
    else $error("fractional word not loaded");

  // First register fields change only on its own write
  r0_hold_a: assert property (@(posedge mclk) disable iff (!rstN)
    !wrR0 |=> $stable(integerWord) && $stable(fractional_numerator))
    else $error("first register changed without write");

  // Second register is staged whole on its strobe
  r1_stage_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR1 |=> r1Stage_r == $past(shift_r))
    else $error("second register not staged");

  // Phase and modulus follow the staged word on a commit
  r1_commit_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR0 |=> fractional_modulus == $past(r1Stage_r[sscw_pkg::MOD_LSB +: sscw_pkg::MOD_W])
      && phaseWord == $past(r1Stage_r[sscw_pkg::PHASE_LSB +: sscw_pkg::MOD_W]))
    else $error("phase or modulus not committed");

  // Phase and modulus never move between commits
  r1_hold_a: assert property (@(posedge mclk) disable iff (!rstN)
    !wrR0 |=> $stable(phaseWord) && $stable(fractional_modulus))
    else $error("buffered field moved early");

  // Prescaler select changes only on a second-register write
  presc_hold_a: assert property (@(posedge mclk) disable iff (!rstN)
    !wrR1 |=> $stable(prescaler_select))
    else $error("prescaler changed without write");

  // Third-register write: unmarked fields now, marked fields kept
  r2_imm_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR2 |=> ((refCpWord & ~R2_BUF_MASK) == ($past(shift_r) & ~R2_BUF_MASK))
      && ((refCpWord & R2_BUF_MASK) == $past(refCpWord & R2_BUF_MASK)))
    else $error("third register fields split wrongly");

  // Marked third-register fields follow staging on a commit
  r2_commit_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR0 |=> (refCpWord & R2_BUF_MASK) == $past(r2Stage_r & R2_BUF_MASK))
    else $error("third register fields not committed");

  // Third register is staged whole on its strobe
  r2_stage_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR2 |=> r2Stage_r == $past(shift_r))
    else $error("third register not staged");

  // Fourth register loads at once
  clkdiv_load_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR3 |=> clkDivWord == $past(shift_r))
    else $error("fourth register not loaded");

  // Fifth register loads at once
  outstg_load_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR4 |=> outStageWord == $past(shift_r))
    else $error("fifth register not loaded");

  // Sixth register loads at once
  lockpin_load_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR5 |=> lockPinWord == $past(shift_r))
    else $error("sixth register not loaded");

  // Fifth register is staged for the divider select
  r4_stage_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR4 |=> r4Stage_r == $past(shift_r))
    else $error("fifth register not staged");

  // Staging latches hold while no strobe selects them
  stage_quiet_a: assert property (@(posedge mclk) disable iff (!rstN)
    (!wrR1 && !wrR2 && !wrR4) |=> $stable(r1Stage_r) && $stable(r2Stage_r) && $stable(r4Stage_r))
    else $error("staging latch moved without strobe");

  // Immediate words hold between strobes
  word_quiet_a: assert property (@(posedge mclk) disable iff (!rstN)
    !leRise |=> $stable(clkDivWord) && $stable(outStageWord) && $stable(lockPinWord))
    else $error("immediate word moved without strobe");

  // Divider select takes the staged value on a commit
  div_commit_a: assert property (@(posedge mclk) disable iff (!rstN)
    wrR0 |=> outDivider == $past(stagedDiv))
    else $error("divider not committed");

  // Divider select holds without a first or fifth register write
  div_quiet_a: assert property (@(posedge mclk) disable iff (!rstN)
    (!wrR0 && !wrR4) |=> $stable(outDivider))
    else $error("divider moved without write");

  // Band timer steps down once per reference tick
  band_tick_a: assert property (@(posedge mclk) disable iff (!rstN)
    (refTick && bandSelBusy && !wrR0) |=> bandCnt_r == $past(bandCnt_r) - 12'h001)
    else $error("band timer missed a tick");

  // Band timer waits between ticks
  band_wait_a: assert property (@(posedge mclk) disable iff (!rstN)
    (!refTick && !wrR0) |=> $stable(bandCnt_r))
    else $error("band timer moved without tick");

  // Band timer stays idle until the next first-register write
  band_floor_a: assert property (@(posedge mclk) disable iff (!rstN)
    (!bandSelBusy && !wrR0) |=> !bandSelBusy)
    else $error("band selection restarted on its own");
endmodule
`default_nettype wire

/* File: tb/sscw_host.sv */
// Purpose: Host model that shifts control words into the bank over the three-wire link.
// Assumes: Pin levels are held for at least two mclk cycles each, so the bank's synchronisers see every edge.
// Notes: The slow input stretches both serial clock phases, so the bank is exercised with a lagging host as well.
`timescale 1ns/100ps
`default_nettype none
module sscw_host (
  // Clock
  input wire logic mclk,
  // Request from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [31:0] word,
  // Serial link pins and done flag
  output logic serialClk,
  output logic serialData,
  output logic load_strobe,
  output logic done
);
  // One word per request; the serial clock stands low outside frames
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    load_strobe = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge mclk);
      if (go) begin
        done <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
          serialData <= word[i]; // Most significant bit first
          repeat (2 + 3 * slow) @(posedge mclk);
          serialClk <= 1'b1; // Data already stable at the rise
          repeat (2 + 3 * slow) @(posedge mclk);
          serialClk <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        serialData <= ~serialData; // Inverted data line: no stale bit left behind
        load_strobe <= 1'b1; // Commit into the selected latch
        repeat (3) @(posedge mclk);
        load_strobe <= 1'b0;
        repeat (2) @(posedge mclk);
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/sscw_bank_tb.sv */
// Purpose: Self-checking bench for the serial control word bank.
// Assumes: Words are written sixth latch down to first, with legal field values.
// Notes: refTick is gated off until the band test so the band timer count is exact.
`timescale 1ns/100ps
`default_nettype none
module sscw_bank_tb;
  typedef struct {logic [31:0] word; int sel; logic [31:0] expVal;} sscw_row_t;
  logic mclk = 1'b0;
  logic nrst, serialClk, serialData, load_strobe, refTick, go, slow, done, tickEn;
  logic [31:0] word, refCpWord, clkDivWord, outStageWord, lockPinWord;
  logic [15:0] integerWord;
  logic [11:0] fractional_numerator, phaseWord, fractional_modulus;
  logic [2:0] outDivider;
  logic prescaler_select, bandSelBusy;
  int nMismatch = 0, samplesChecked = 0, cycles = 0, n;
  // Reserved bits and legal ranges are kept in every row
  sscw_row_t rows [6] = '{'{32'h0018_0005, 0, 32'h0018_0005}, '{32'h0030_2004, 1, 32'h0000_0003},
    '{32'h0000_8013, 2, 32'h0000_8013}, '{32'h0000_6002, 3, 32'h0000_2002},
    '{32'h0800_8321, 4, 32'h0000_0001}, '{32'h0025_8038, 5, 32'h0000_004B}};
  sscw_host u_sscw_host (.mclk(mclk), .go(go), .slow(slow), .word(word), .serialClk(serialClk),
    .serialData(serialData), .load_strobe(load_strobe), .done(done));
  sscw_bank u_sscw_bank (.mclk(mclk), .nrst(nrst), .serialClk(serialClk), .serialData(serialData),
    .load_strobe(load_strobe), .refTick(refTick), .integerWord(integerWord),
    .fractional_numerator(fractional_numerator), .prescaler_select(prescaler_select), .phaseWord(phaseWord),
    .fractional_modulus(fractional_modulus), .refCpWord(refCpWord), .clkDivWord(clkDivWord),
    .outStageWord(outStageWord), .lockPinWord(lockPinWord), .outDivider(outDivider), .bandSelBusy(bandSelBusy));
  // Clock
  always #2.5 mclk = ~mclk;
  // Reference tick every fourth cycle, and a ceiling on the whole run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    refTick <= tickEn && (cycles % 4 == 3);
    if (cycles == 20000) begin
      nMismatch++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Hand one word to the host and wait, bounded, until it has been committed
  task automatic send(input logic [31:0] w);
    int t;
    word <= w;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (done !== 1'b1 && t < 2000);
    repeat (4) @(posedge mclk);
  endtask
  function automatic logic [31:0] obs(input int sel);
    case (sel)
      0: obs = lockPinWord;
      1: obs = 32'(outDivider);
      2: obs = clkDivWord;
      3: obs = refCpWord;
      4: obs = 32'(prescaler_select);
      default: obs = 32'(integerWord);
    endcase
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    tickEn = 1'b0;
    word = 32'h0000_0000;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    check(refCpWord | lockPinWord | 32'(integerWord) | 32'(bandSelBusy), 32'h0, "reset");
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      send(rows[r].word);
      check(obs(rows[r].sel), rows[r].expVal, "row");
    end
    $display("test rows done");
    check(32'(fractional_numerator), 32'h7, "fractional_numerator");
    check(32'(fractional_modulus), 32'd100, "mod");
    check(32'(phaseWord), 32'h1, "phase");
    check(refCpWord, 32'h0000_6002, "refcp");
    check(outStageWord, 32'h0030_2004, "outstg");
    // Reserved code 110 must leave every latch alone
    send(32'hFFFF_FFFE);
    check(lockPinWord, 32'h0018_0005, "code6");
    check(32'(integerWord), 32'd75, "code6 int");
    // Divider select held back while the buffer enable bit is set, slow host
    slow <= 1'b1;
    send(32'h0050_2004);
    slow <= 1'b0;
    check(32'(outDivider), 32'h3, "dbb hold");
    send(32'h0025_8038);
    check(32'(outDivider), 32'h5, "dbb commit");
    $display("test buffering done");
    // Band selection lasts ten ticks per divider step
    check(32'(bandSelBusy), 32'h1, "band start");
    tickEn <= 1'b1;
    n = 0;
    for (int c = 0; c < 500 && bandSelBusy === 1'b1; c++) begin
      @(posedge mclk);
      if (refTick === 1'b1 && bandSelBusy === 1'b1) n++;
    end
    check(32'(n), 32'(sscw_pkg::BAND_CYCLES * 2), "band ticks");
    $display("test band done");
    // Reset in mid-run clears every latch; the link works again after release
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    check(refCpWord | clkDivWord | outStageWord | lockPinWord, 32'h0000_0000, "reset words");
    check({integerWord, fractional_numerator, outDivider, prescaler_select}, 32'h0000_0000, "reset r0");
    check({7'h00, bandSelBusy, phaseWord, fractional_modulus}, 32'h0000_0000, "reset r1");
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    send(rows[0].word);
    check(lockPinWord, rows[0].expVal, "after reset");
    $display("test mid reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
